// >>> verilog/otc_pkg.sv
//------------------------------------------------------------
// oscillator trim calibration: shared constants and types
//------------------------------------------------------------
package otc_pkg;

	// register byte addresses
	localparam logic [31:0] OTC_CC_CTRL_OFF  = 32'hFFFF0440;
	localparam logic [31:0] OTC_CC_STAT_OFF  = 32'hFFFF0444;
	localparam logic [31:0] OTC_REF_CNT_OFF  = 32'hFFFF0448;
	localparam logic [31:0] OTC_LP_CNT_OFF   = 32'hFFFF044C;
	localparam logic [31:0] OTC_LIN_CTRL_OFF = 32'hFFFF0480;
	localparam logic [31:0] OTC_LP_USR_OFF   = 32'hFFFF0484;
	localparam logic [31:0] OTC_PR_USR_OFF   = 32'hFFFF0488;
	localparam logic [31:0] OTC_BAUD_MAX_OFF = 32'hFFFF048C;
	localparam logic [31:0] OTC_BAUD_MIN_OFF = 32'hFFFF0490;
	localparam logic [31:0] OTC_LIN_STAT_OFF = 32'hFFFF0494;
	localparam logic [31:0] OTC_LP_WRK_OFF   = 32'hFFFF0498;
	localparam logic [31:0] OTC_PR_WRK_OFF   = 32'hFFFF049C;
	localparam logic [31:0] OTC_KEY_OFF      = 32'hFFFF04A0;

	// key, counts, field positions and reset values
	localparam logic [15:0] OTC_KEY_VALUE    = 16'h1324;
	localparam logic [8:0]  OTC_REF_FULL     = 9'h1FF;
	localparam logic [2:0]  OTC_LIN_CTRL_RST = 3'h0;
	localparam logic [19:0] OTC_LIMIT_RST    = 20'h00000;
	localparam logic        OTC_TARGET_RST   = 1'b1;
	localparam int          OTC_CC_EN_BIT    = 0;
	localparam int          OTC_CC_CLR0_BIT  = 1;
	localparam int          OTC_CC_CLR1_BIT  = 2;
	localparam int          OTC_CC_RST_BIT   = 3;
	localparam int          OTC_LIN_EN_BIT   = 0;
	localparam logic [1:0]  OTC_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  OTC_RESP_SLVERR  = 2'h2;

	// counter calibration sequencer, one-hot
	typedef enum logic [2:0] {
		OTC_CC_IDLE = 3'b001,
		OTC_CC_RUN  = 3'b010,
		OTC_CC_DONE = 3'b100
	} otc_cc_state_t;

	// axi4-lite master to slave
	typedef struct packed {
		logic        awvalid;
		logic [31:0] awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [31:0] araddr;
		logic        rready;
	} otc_axi_req_t;

	// axi4-lite slave to master
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} otc_axi_rsp_t;

endpackage : otc_pkg

// >>> verilog/otc_top.sv
`timescale 1ns/1ps
// Functional notes
// - complete set at end, lp count read clears
// - busy high while counter calibration runs
// - finish flag on busy fall, cleared reading status
// - 9-bit reference counter on precision ticks, resets zero
// - 10-bit low power counter, 11 bits read
// - step trim when measurement leaves limits
// - auto calibration changes only working trims
// - step code n gives step n plus one
// - control bit zero enables automatic trimming
// - status bit two: low power trim altered
// - status bit one: precision trim altered
// - status bit zero: target, resets to one
// - protected writes need preceding unlock key
// - key-protected control and user trims, control zero
// - writable upper and lower limits reset zero
// - read-only working trim for each oscillator
// - trim derived from measured synchronization timing
// - full reference count stops both counters
// - control: start, clear each, reset all
// - larger low power trim means lower frequency
module otc_top #(
	parameter logic [7:0] LP_TRIM_RST = 8'h80,  // stand-in for factory value
	parameter logic [9:0] PR_TRIM_RST = 10'h200 // stand-in for factory value
) (
	input  wire logic                  i_mclk,
	input  wire logic                  i_sys_rst,
	input  wire otc_pkg::otc_axi_req_t i_axi,
	output otc_pkg::otc_axi_rsp_t      o_axi,
	input  wire logic                  i_prec_osc_tick,
	input  wire logic                  i_lp_osc_tick,
	input  wire logic                  i_lin_meas_valid,
	input  wire logic [19:0]           i_lin_baud_meas,
	input  wire logic                  i_cal_target_lp,
	output logic [7:0]                 o_lp_trim,
	output logic [9:0]                 o_prec_trim,
	output logic                       o_cal_finished
);
	import otc_pkg::*;

	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	logic          aw_rdy_q, w_rdy_q, ar_rdy_q;  // bus channel readies
	logic          aw_have_q, w_have_q;          // captured halves
	logic [31:0]   awaddr_q, wdata_q;            // held write request
	logic [3:0]    wstrb_q;                      // held byte lanes
	logic          bvalid_q, rvalid_q;           // answers pending
	logic [1:0]    bresp_q, rresp_q;             // answer codes
	logic [31:0]   rdata_q;                      // read answer word
	logic [3:0]    cc_ctrl_q;                    // counter cal control
	otc_cc_state_t cc_state_q, cc_state_d;       // counter sequencer
	logic [8:0]    ref_cnt_q;                    // reference counter
	logic [9:0]    lp_cnt_q;                     // low power counter
	logic          complete_q, fin_q;            // counter cal flags
	logic [2:0]    lin_ctrl_q;                   // step code and enable
	logic [7:0]    lp_usr_q, lp_wrk_q;           // low power trims
	logic [9:0]    pr_usr_q, pr_wrk_q;           // precision trims
	logic [19:0]   max_q, min_q;                 // baud limits
	logic          target_q;                     // 1: low power target
	logic          lp_mod_q, pr_mod_q;           // trim altered flags
	logic          unlock_q;                     // one-shot key state

	//------------------------------------------------------------
	// bus handshakes and decode
	//------------------------------------------------------------
	wire aw_hs    = i_axi.awvalid & aw_rdy_q;
	wire w_hs     = i_axi.wvalid & w_rdy_q;
	wire ar_hs    = i_axi.arvalid & ar_rdy_q;
	wire do_write = aw_have_q & w_have_q;  // both halves in hand
	wire [31:0] wa = {awaddr_q[31:2], 2'b00};
	wire [31:0] ra = {i_axi.araddr[31:2], 2'b00};

	// write targets
	wire wr_cc_ctrl  = do_write & (wa == OTC_CC_CTRL_OFF);
	wire wr_lin_ctrl = do_write & (wa == OTC_LIN_CTRL_OFF);
	wire wr_lp_usr   = do_write & (wa == OTC_LP_USR_OFF);
	wire wr_pr_usr   = do_write & (wa == OTC_PR_USR_OFF);
	wire wr_max      = do_write & (wa == OTC_BAUD_MAX_OFF);
	wire wr_min      = do_write & (wa == OTC_BAUD_MIN_OFF);
	wire wr_key      = do_write & (wa == OTC_KEY_OFF);
	wire wr_prot     = wr_lin_ctrl | wr_lp_usr | wr_pr_usr;
	wire prot_ok     = wr_prot & unlock_q;
	wire wr_ro       = do_write & ((wa == OTC_CC_STAT_OFF) |
		(wa == OTC_REF_CNT_OFF) | (wa == OTC_LP_CNT_OFF) |
		(wa == OTC_LIN_STAT_OFF) | (wa == OTC_LP_WRK_OFF) |
		(wa == OTC_PR_WRK_OFF));
	// read-only targets silently ignore writes; unmapped ones fail
	wire wr_err = (wr_prot & ~unlock_q) |
		~(wr_cc_ctrl | wr_prot | wr_max | wr_min | wr_key | wr_ro);

	// read targets with side effects
	wire rd_cc_stat  = ar_hs & (ra == OTC_CC_STAT_OFF);
	wire rd_lp_cnt   = ar_hs & (ra == OTC_LP_CNT_OFF);
	wire rd_lin_stat = ar_hs & (ra == OTC_LIN_STAT_OFF);

	// byte-lane merge of the held write into an old value
	function automatic logic [31:0] otc_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
		begin
			if (s[b])
			begin
				r[b*8 +: 8] = n[b*8 +: 8];
			end
		end
		return r;
	endfunction : otc_merge

	wire [31:0] wmask = otc_merge(32'h00000000, wdata_q, wstrb_q);

	//------------------------------------------------------------
	// read mux
	//------------------------------------------------------------
	logic [31:0] rd_word;
	logic        rd_err;
	always_comb
	begin
		rd_word = 32'h00000000;
		rd_err  = 1'b0;
		unique case (ra)
			OTC_CC_CTRL_OFF:  rd_word = {28'h0000000, cc_ctrl_q};
			OTC_CC_STAT_OFF:  rd_word = {29'h00000000, complete_q,
				cc_state_q == OTC_CC_RUN, fin_q};
			OTC_REF_CNT_OFF:  rd_word = {23'h000000, ref_cnt_q};
			OTC_LP_CNT_OFF:   rd_word = {21'h000000, 1'b0, lp_cnt_q};
			OTC_LIN_CTRL_OFF: rd_word = {29'h00000000, lin_ctrl_q};
			OTC_LP_USR_OFF:   rd_word = {24'h000000, lp_usr_q};
			OTC_PR_USR_OFF:   rd_word = {22'h000000, pr_usr_q};
			OTC_BAUD_MAX_OFF: rd_word = {12'h000, max_q};
			OTC_BAUD_MIN_OFF: rd_word = {12'h000, min_q};
			OTC_LIN_STAT_OFF: rd_word = {29'h00000000, lp_mod_q,
				pr_mod_q, target_q};
			OTC_LP_WRK_OFF:   rd_word = {24'h000000, lp_wrk_q};
			OTC_PR_WRK_OFF:   rd_word = {21'h000000, 1'b0, pr_wrk_q};
			OTC_KEY_OFF:      rd_word = 32'h00000000;  // write-only
			default:          rd_err  = 1'b1;
		endcase
	end

	//------------------------------------------------------------
	// bus slave channels
	//------------------------------------------------------------
	wire aw_have_d = (aw_have_q | aw_hs) & ~do_write;
	wire w_have_d  = (w_have_q | w_hs) & ~do_write;
	wire bvalid_d  = (bvalid_q & ~i_axi.bready) | do_write;
	wire rvalid_d  = (rvalid_q & ~i_axi.rready) | ar_hs;

	// one write and one read in flight; readies drop while busy
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			aw_rdy_q  <= 1'b0;
			w_rdy_q   <= 1'b0;
			ar_rdy_q  <= 1'b0;
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			rvalid_q  <= 1'b0;
		end
		else
		begin
			aw_rdy_q  <= ~aw_have_d & ~bvalid_d;
			w_rdy_q   <= ~w_have_d & ~bvalid_d;
			ar_rdy_q  <= ~rvalid_d;
			aw_have_q <= aw_have_d;
			w_have_q  <= w_have_d;
			bvalid_q  <= bvalid_d;
			rvalid_q  <= rvalid_d;
		end
	end

	// payload capture, held until the answer is taken
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			awaddr_q <= 32'h00000000;
			wdata_q  <= 32'h00000000;
			wstrb_q  <= 4'h0;
			bresp_q  <= OTC_RESP_OKAY;
			rdata_q  <= 32'h00000000;
			rresp_q  <= OTC_RESP_OKAY;
		end
		else
		begin
			if (aw_hs)
				awaddr_q <= i_axi.awaddr;
			if (w_hs)
			begin
				wdata_q <= i_axi.wdata;
				wstrb_q <= i_axi.wstrb;
			end
			if (do_write)
				bresp_q <= wr_err ? OTC_RESP_SLVERR : OTC_RESP_OKAY;
			if (ar_hs)
			begin
				rdata_q <= rd_word;
				rresp_q <= rd_err ? OTC_RESP_SLVERR : OTC_RESP_OKAY;
			end
		end
	end

	assign o_axi = '{awready: aw_rdy_q, wready: w_rdy_q, bvalid: bvalid_q,
		bresp: bresp_q, arready: ar_rdy_q, rvalid: rvalid_q,
		rdata: rdata_q, rresp: rresp_q};

	//------------------------------------------------------------
	// counter calibration
	//------------------------------------------------------------
	wire cc_en   = cc_ctrl_q[OTC_CC_EN_BIT];
	wire cc_rst  = cc_ctrl_q[OTC_CC_RST_BIT];
	wire clr_ref = cc_rst | cc_ctrl_q[OTC_CC_CLR0_BIT];
	wire clr_lp  = cc_rst | cc_ctrl_q[OTC_CC_CLR1_BIT];
	// a held clear beats the last tick, so done always means full
	wire ref_top = i_prec_osc_tick & ~clr_ref &
		(ref_cnt_q == OTC_REF_FULL - 9'h001);
	wire cc_fin  = (cc_state_q == OTC_CC_RUN) & (cc_state_d != OTC_CC_RUN);

	// sequencer; a run needs enable, no reset, and room to count
	always_comb
	begin
		cc_state_d = cc_state_q;
		unique case (cc_state_q)
			OTC_CC_IDLE:
				if (cc_en & ~cc_rst & (ref_cnt_q != OTC_REF_FULL))
					cc_state_d = OTC_CC_RUN;
			OTC_CC_RUN:
				if (~cc_en | cc_rst)
					cc_state_d = OTC_CC_IDLE;  // abort
				else if (ref_top)
					cc_state_d = OTC_CC_DONE;
			OTC_CC_DONE:
				if (~cc_en | cc_rst)
					cc_state_d = OTC_CC_IDLE;
			default:
				cc_state_d = OTC_CC_IDLE;
		endcase
	end

	// counters count only in the run state, so both freeze together
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cc_state_q <= OTC_CC_IDLE;
			cc_ctrl_q  <= 4'h0;
			ref_cnt_q  <= 9'h000;
			lp_cnt_q   <= 10'h000;
		end
		else
		begin
			cc_state_q <= cc_state_d;
			if (wr_cc_ctrl)
				cc_ctrl_q <= wmask[3:0];
			if (clr_ref)
				ref_cnt_q <= 9'h000;
			else if (cc_state_q == OTC_CC_RUN & i_prec_osc_tick)
				ref_cnt_q <= ref_cnt_q + 9'h001;
			if (clr_lp)
				lp_cnt_q <= 10'h000;
			else if (cc_state_q == OTC_CC_RUN & i_lp_osc_tick)
				lp_cnt_q <= lp_cnt_q + 10'h001;
		end
	end

	// sticky flags; a set in the clearing cycle wins
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			complete_q     <= 1'b0;
			fin_q          <= 1'b0;
			o_cal_finished <= 1'b0;
		end
		else
		begin
			if (cc_fin & ref_top)
				complete_q <= 1'b1;
			else if (rd_lp_cnt)
				complete_q <= 1'b0;
			if (cc_fin)
				fin_q <= 1'b1;
			else if (rd_cc_stat)
				fin_q <= 1'b0;
			o_cal_finished <= cc_fin | (fin_q & ~rd_cc_stat);
		end
	end

	//------------------------------------------------------------
	// lin based trimming
	//------------------------------------------------------------
	wire       lin_en  = lin_ctrl_q[OTC_LIN_EN_BIT];
	wire [2:0] step    = {1'b0, lin_ctrl_q[2:1]} + 3'h1;
	// each measurement times one synchronization field at a fixed rate
	wire       meas_hi = i_lin_baud_meas > max_q;
	wire       meas_lo = i_lin_baud_meas < min_q;
	wire       adjust  = lin_en & i_lin_meas_valid & (meas_hi | meas_lo);
	wire       lp_auto = lin_en & target_q;
	wire       pr_auto = lin_en & ~target_q;

	// saturating steps; larger trim slows the oscillator
	wire [8:0]  lp_up = {1'b0, lp_wrk_q} + {6'h00, step};
	wire [10:0] pr_up = {1'b0, pr_wrk_q} + {8'h00, step};
	wire [7:0]  lp_inc = lp_up[8] ? 8'hFF : lp_up[7:0];
	wire [9:0]  pr_inc = pr_up[10] ? 10'h3FF : pr_up[9:0];
	wire [7:0]  lp_dec = (lp_wrk_q < {5'h00, step}) ? 8'h00 :
		lp_wrk_q - {5'h00, step};
	wire [9:0]  pr_dec = (pr_wrk_q < {7'h00, step}) ? 10'h000 :
		pr_wrk_q - {7'h00, step};
	wire [7:0]  lp_new = meas_hi ? lp_inc : lp_dec;
	wire [9:0]  pr_new = meas_hi ? pr_inc : pr_dec;
	wire        lp_chg = adjust & target_q & (lp_new != lp_wrk_q);
	wire        pr_chg = adjust & ~target_q & (pr_new != pr_wrk_q);

	// key-protected registers and limits
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			lin_ctrl_q <= OTC_LIN_CTRL_RST;
			lp_usr_q   <= LP_TRIM_RST;
			pr_usr_q   <= PR_TRIM_RST;
			max_q      <= OTC_LIMIT_RST;
			min_q      <= OTC_LIMIT_RST;
			unlock_q   <= 1'b0;
		end
		else
		begin
			if (wr_lin_ctrl & unlock_q)
				lin_ctrl_q <= wmask[2:0];
			if (wr_lp_usr & unlock_q)
				lp_usr_q <= wmask[7:0];
			if (wr_pr_usr & unlock_q)
				pr_usr_q <= wmask[9:0];
			if (wr_max)
				max_q <= wmask[19:0];
			if (wr_min)
				min_q <= wmask[19:0];
			if (wr_key)
				unlock_q <= wmask[15:0] == OTC_KEY_VALUE;
			else if (wr_prot)
				unlock_q <= 1'b0;
		end
	end

	// working trims follow user trims unless the lin loop owns them;
	// software must save them before disabling, or they snap back
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			lp_wrk_q <= LP_TRIM_RST;
			pr_wrk_q <= PR_TRIM_RST;
		end
		else
		begin
			if (~lp_auto)
				lp_wrk_q <= lp_usr_q;
			else if (lp_chg)
				lp_wrk_q <= lp_new;
			if (~pr_auto)
				pr_wrk_q <= pr_usr_q;
			else if (pr_chg)
				pr_wrk_q <= pr_new;
		end
	end

	// status flags and trim outputs
	always_ff @(posedge i_mclk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			target_q    <= OTC_TARGET_RST;
			lp_mod_q    <= 1'b0;
			pr_mod_q    <= 1'b0;
			o_lp_trim   <= LP_TRIM_RST;
			o_prec_trim <= PR_TRIM_RST;
		end
		else
		begin
			target_q <= i_cal_target_lp;
			if (lp_chg)
				lp_mod_q <= 1'b1;
			else if (rd_lin_stat)
				lp_mod_q <= 1'b0;
			if (pr_chg)
				pr_mod_q <= 1'b1;
			else if (rd_lin_stat)
				pr_mod_q <= 1'b0;
			o_lp_trim   <= lp_wrk_q;
			o_prec_trim <= pr_wrk_q;
		end
	end

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);

	complete_set_a: assert property (
		(cc_state_q == OTC_CC_RUN && cc_en && !cc_rst && ref_top)
		|=> complete_q && ref_cnt_q == OTC_REF_FULL)
		else $error("complete flag missed at full count");
	complete_clr_a: assert property (
		(rd_lp_cnt && !(cc_fin && ref_top)) |=> !complete_q)
		else $error("complete flag not cleared by count read");
	busy_fall_a: assert property (
		(cc_state_q == OTC_CC_RUN) ##1 (cc_state_q != OTC_CC_RUN) |-> fin_q)
		else $error("finish flag not set on busy fall");
	ref_step_a: assert property (
		(cc_state_q == OTC_CC_RUN && i_prec_osc_tick && !clr_ref)
		|=> ref_cnt_q == $past(ref_cnt_q) + 9'h001)
		else $error("reference counter did not advance");
	full_stop_a: assert property (
		(ref_cnt_q == OTC_REF_FULL && !clr_ref && !clr_lp)
		|=> $stable(ref_cnt_q) && $stable(lp_cnt_q))
		else $error("counters moved after full count");
	lp_up_a: assert property (
		(lp_auto && i_lin_meas_valid && meas_hi && lp_wrk_q < 8'hF0)
		|=> lp_wrk_q == $past(lp_wrk_q) + {5'h00, $past(step)})
		else $error("low power trim not stepped up");
	pr_down_a: assert property (
		(pr_auto && i_lin_meas_valid && meas_lo && !meas_hi &&
		pr_wrk_q > 10'h008) |=> pr_wrk_q == $past(pr_wrk_q) - {7'h00,
		$past(step)})
		else $error("precision trim not stepped down");
	user_guard_a: assert property (
		!(do_write && unlock_q) |=> $stable(lp_usr_q) &&
		$stable(pr_usr_q) && $stable(lin_ctrl_q))
		else $error("protected register changed without key");
	key_once_a: assert property (
		(wr_prot && unlock_q) |=> !unlock_q ##1 1'b1)
		else $error("key allowed more than one write");
	stat_clr_a: assert property (
		(rd_lin_stat && !lp_chg && !pr_chg) |=> !lp_mod_q && !pr_mod_q)
		else $error("lin status flags not cleared by read");

endmodule : otc_top

// >>> test/otc_far_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------
// far side: oscillator ticks and lin baud measurements
// ----------------------------------------------------------
module otc_far_model #(
	parameter int TICK_PER = 2 // cycles per oscillator tick
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_fire,
	input  wire logic [19:0] i_value,
	output logic             o_prec_tick,
	output logic             o_lp_tick,
	output logic             o_valid,
	output logic [19:0]      o_meas
);
	int cnt; // tick divider

	// both oscillators tick together, so both counters end equal
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			cnt         <= 0;
			o_prec_tick <= 1'b0;
			o_lp_tick   <= 1'b0;
			o_valid     <= 1'b0;
			o_meas      <= 20'h00000;
		end
		else
		begin
			cnt         <= (cnt == TICK_PER - 1) ? 0 : cnt + 1;
			o_prec_tick <= (cnt == 0);
			o_lp_tick   <= (cnt == 0);
			o_valid     <= i_fire;
			// outside a pulse the value is garbage on purpose
			o_meas      <= i_fire ? i_value : ~o_meas;
		end
	end
endmodule : otc_far_model

// >>> test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import otc_pkg::*;
	// ------------------------------------------------------
	// signals
	// ------------------------------------------------------
	localparam logic [19:0] BMAX = 20'h010CB;
	localparam logic [19:0] BMIN = 20'h0108B;
	localparam logic [31:0] ONES = 32'hFFFFFFFF;
	logic         mclk = 1'b0;
	logic         sys_rst = 1'b1;
	otc_axi_req_t req = '0;
	otc_axi_rsp_t rsp;
	logic         ptk, ltk, mv, fin;
	logic         tgt_lp = 1'b1;
	logic         fire = 1'b0;
	logic [19:0]  meas;
	logic [19:0]  mval = 20'h00000;
	logic [7:0]   lpt;
	logic [9:0]   prt;
	logic [10:0]  t, e;
	logic [19:0]  m;
	int           n_fail = 0;
	int           samples_checked = 0;
	int           seed = 32'hA7D41619;
	int           k, c, i;
	// reset image: address and expected value
	logic [31:0]  ra [9] = '{OTC_LIN_STAT_OFF, OTC_LIN_CTRL_OFF,
		OTC_BAUD_MAX_OFF, OTC_BAUD_MIN_OFF, OTC_CC_STAT_OFF,
		OTC_REF_CNT_OFF, OTC_LP_CNT_OFF, OTC_LP_WRK_OFF, OTC_PR_WRK_OFF};
	logic [31:0]  re [9] = '{32'h00000001, 32'h00000000, 32'h00000000,
		32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000080, 32'h00000200};

	always #5 mclk = ~mclk;

	otc_top i_dut (.i_mclk(mclk), .i_sys_rst(sys_rst), .i_axi(req),
		.o_axi(rsp), .i_prec_osc_tick(ptk), .i_lp_osc_tick(ltk),
		.i_lin_meas_valid(mv), .i_lin_baud_meas(meas),
		.i_cal_target_lp(tgt_lp), .o_lp_trim(lpt), .o_prec_trim(prt),
		.o_cal_finished(fin));
	otc_far_model #(.TICK_PER(2)) i_far (.i_clk(mclk), .i_rst(sys_rst),
		.i_fire(fire), .i_value(mval), .o_prec_tick(ptk),
		.o_lp_tick(ltk), .o_valid(mv), .o_meas(meas));

	// ------------------------------------------------------
	// helpers
	// ------------------------------------------------------
	task automatic stop_test;
		if (n_fail == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : stop_test

	task automatic to;
		n_fail++;
		stop_test();
	endtask : to

	task automatic chk(input string nm, input logic [31:0] ev, gv);
		samples_checked++;
		if (gv !== ev)
		begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, ev, gv);
		end
	endtask : chk

	// address and data offered together, each dropped when taken
	task automatic wr(input logic [31:0] a, d,
		input logic [1:0] er = OTC_RESP_OKAY);
		@(posedge mclk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= d;
		req.wstrb   <= 4'hF;
		req.bready  <= 1'b1;
		for (k = 0; k < 100; k++)
		begin
			@(posedge mclk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) break;
		end
		req.bready <= 1'b0;
		if (k == 100) to();
		chk("bresp", {30'h0, er}, {30'h0, rsp.bresp});
	endtask : wr

	task automatic rd(input string nm, input logic [31:0] a, ev,
		input logic [1:0] er = OTC_RESP_OKAY,
		input logic [31:0] msk = ONES);
		@(posedge mclk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		for (k = 0; k < 100; k++)
		begin
			@(posedge mclk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) break;
		end
		req.rready <= 1'b0;
		if (k == 100) to();
		chk(nm, ev & msk, rsp.rdata & msk);
		chk("rresp", {30'h0, er}, {30'h0, rsp.rresp});
	endtask : rd

	// one measurement pulse from the far side
	task automatic lin(input logic [19:0] mm);
		@(posedge mclk);
		mval <= mm;
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
	endtask : lin

	// above, below, or exactly on either limit
	function automatic logic [19:0] pick();
		logic [7:0] r;
		r = 8'($random(seed));
		case (r[1:0])
			2'h0: return BMAX + {14'h0, r[7:2]} + 20'h00001;
			2'h1: return BMIN - {14'h0, r[7:2]} - 20'h00001;
			2'h2: return BMAX;
			default: return BMIN;
		endcase
	endfunction : pick

	// expected low power trim after one measurement
	function automatic logic [10:0] nxt(input logic [10:0] tv,
		input logic [19:0] mm, input int cc);
		int v;
		v = int'(tv);
		if (mm > BMAX) v = v + cc + 1;
		else if (mm < BMIN) v = v - cc - 1;
		if (v > 255) v = 255;
		if (v < 0) v = 0;
		return v[10:0];
	endfunction : nxt

	// ------------------------------------------------------
	// main sequence
	// ------------------------------------------------------
	initial
	begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		for (i = 0; i < 9; i++)
			rd("reset image", ra[i], re[i]);
		// counter calibration, both counters on equal ticks
		wr(OTC_CC_CTRL_OFF, 32'h00000001);
		rd("cc busy", OTC_CC_STAT_OFF, 32'h00000002);
		for (i = 0; i < 3000 && fin !== 1'b1; i++)
			@(posedge mclk);
		if (i == 3000) to();
		rd("cc done", OTC_CC_STAT_OFF, 32'h00000005);
		rd("cc read", OTC_CC_STAT_OFF, 32'h00000004);
		chk("o_cal_finished", 32'h00000000, {31'h0, fin});
		rd("ref count", OTC_REF_CNT_OFF, 32'h000001FF);
		rd("lp count", OTC_LP_CNT_OFF, 32'h000001FF);
		rd("cc final", OTC_CC_STAT_OFF, 32'h00000000);
		wr(OTC_REF_CNT_OFF, 32'h00000005);
		wr(OTC_CC_CTRL_OFF, 32'h00000008);
		rd("ref clear", OTC_REF_CNT_OFF, 32'h00000000);
		rd("lp clear", OTC_LP_CNT_OFF, 32'h00000000);
		// abort mid-run: finish without complete, then single clears
		wr(OTC_CC_CTRL_OFF, 32'h00000001);
		wr(OTC_CC_CTRL_OFF, 32'h00000004);
		rd("cc abort", OTC_CC_STAT_OFF, 32'h00000001);
		rd("lp clr1", OTC_LP_CNT_OFF, 32'h00000000);
		wr(OTC_CC_CTRL_OFF, 32'h00000002);
		rd("ref clr0", OTC_REF_CNT_OFF, 32'h00000000);
		// limits, key protection, user trim near the top
		wr(OTC_BAUD_MAX_OFF, {12'h000, BMAX});
		wr(OTC_BAUD_MIN_OFF, {12'h000, BMIN});
		wr(OTC_LIN_CTRL_OFF, 32'h00000001, OTC_RESP_SLVERR);
		rd("ctrl locked", OTC_LIN_CTRL_OFF, 32'h00000000);
		wr(OTC_KEY_OFF, {16'h0000, OTC_KEY_VALUE});
		wr(OTC_LP_USR_OFF, 32'h000000FD);
		wr(OTC_LP_USR_OFF, 32'h00000001, OTC_RESP_SLVERR);
		rd("lp user", OTC_LP_USR_OFF, 32'h000000FD);
		rd("lp copy", OTC_LP_WRK_OFF, 32'h000000FD);
		rd("sta flush", OTC_LIN_STAT_OFF, 32'h00000001, OTC_RESP_OKAY,
			32'h00000001);
		t = 11'h0FD;
		// every step code, random measurements with limit corners
		for (c = 0; c < 4; c++)
		begin
			wr(OTC_KEY_OFF, {16'h0000, OTC_KEY_VALUE});
			wr(OTC_LIN_CTRL_OFF, {29'h0, c[1:0], 1'b1});
			rd("lin ctrl", OTC_LIN_CTRL_OFF, {29'h0, c[1:0], 1'b1});
			for (i = 0; i < 6; i++)
			begin
				m = pick();
				e = nxt(t, m, c);
				lin(m);
				rd("lp trim", OTC_LP_WRK_OFF, {21'h0, e});
				rd("lin sta", OTC_LIN_STAT_OFF,
					{29'h0, e != t, 2'b01});
				t = e;
			end
		end
		chk("o_lp_trim", {21'h0, t}, {24'h0, lpt});
		rd("lp user kept", OTC_LP_USR_OFF, 32'h000000FD);
		// in-range measurement leaves the trim, then software saves it
		lin(BMAX);
		rd("lp steady", OTC_LP_WRK_OFF, {21'h0, t});
		wr(OTC_KEY_OFF, {16'h0000, OTC_KEY_VALUE});
		wr(OTC_LP_USR_OFF, {21'h0, t});
		rd("lp saved", OTC_LP_USR_OFF, {21'h0, t});
		// precision oscillator as target, step code 3 still set
		tgt_lp <= 1'b0;
		rd("sta flush", OTC_LIN_STAT_OFF, 32'h00000000, OTC_RESP_OKAY,
			32'h00000000);
		rd("lp kept", OTC_LP_WRK_OFF, {21'h0, t});
		lin(BMAX + 20'h00001);
		rd("pr trim", OTC_PR_WRK_OFF, 32'h00000204);
		rd("pr sta", OTC_LIN_STAT_OFF, 32'h00000002, OTC_RESP_OKAY,
			32'h00000003);
		chk("o_prec_trim", 32'h00000204, {22'h0, prt});
		lin(BMIN - 20'h00001);
		rd("pr trim down", OTC_PR_WRK_OFF, 32'h00000200);
		// wrong key leaves protection armed
		wr(OTC_KEY_OFF, 32'h00001325);
		wr(OTC_PR_USR_OFF, 32'h00000003, OTC_RESP_SLVERR);
		rd("pr user", OTC_PR_USR_OFF, 32'h00000200);
		rd("unmapped", 32'hFFFF0400, 32'h00000000, OTC_RESP_SLVERR);
		stop_test();
	end
endmodule : testbench
